// *** inc/ims_pkg.sv ***
// Package for the index move status and registration block.
// Assumes a single 20 MHz clock and a motion update strobe from the drive.
package ims_pkg;

	localparam int          IMS_POS_W        = 32;
	localparam int          IMS_IDX_W        = 3;
	localparam int          IMS_NUM_IDX      = 8;
	localparam int          IMS_ANA_W        = 16;
	localparam int          IMS_CLK_MHZ      = 20;

	// Registration trigger sources.
	localparam logic [1:0]  IMS_SRC_ANALOG   = 2'h0;
	localparam logic [1:0]  IMS_SRC_TQ_CMD   = 2'h1;
	localparam logic [1:0]  IMS_SRC_TQ_FB    = 2'h2;
	localparam logic [1:0]  IMS_SRC_SENSOR   = 2'h3;

	// Move phases reported by the profile generator.
	localparam logic [1:0]  IMS_PH_IDLE      = 2'h0;
	localparam logic [1:0]  IMS_PH_ACCEL     = 2'h1;
	localparam logic [1:0]  IMS_PH_CRUISE    = 2'h2;
	localparam logic [1:0]  IMS_PH_DECEL     = 2'h3;

	typedef enum logic [3:0] {
		IMS_IDLE   = 4'h1,
		IMS_RUN    = 4'h2,
		IMS_FINISH = 4'h4,
		IMS_LIMIT  = 4'h8
	} ims_state_t;

	// Absolute value of a signed distance.
	function automatic logic [IMS_POS_W-1:0] ims_abs(input logic signed [IMS_POS_W-1:0] v);
		ims_abs = v[IMS_POS_W-1] ? IMS_POS_W'(-v) : IMS_POS_W'(v);
	endfunction : ims_abs

	// True when d lies in [lo, hi).
	function automatic logic ims_in_range(input logic [IMS_POS_W-1:0] d,
		input logic [IMS_POS_W-1:0] lo, input logic [IMS_POS_W-1:0] hi);
		ims_in_range = (d >= lo) && (d < hi);
	endfunction : ims_in_range

endpackage : ims_pkg

// *** rtl/ims_core.sv ***
// Per-index status, switch output and registration logic.
// Assumes a profile generator that reports phase and commanded distance per update.

// Contract
// RL1 - Switch output on while travelled distance lies between on and off points.
// RL2 - Move ending between points keeps switch on until index restarts.
// RL3 - Move ending before on point never turns switch on.
// RL4 - Switch works for every index type.
// RL5 - Trigger from digital source or analog greater/less comparison.
// RL6 - Sensor trigger latches motor position as registration point.
// RL7 - After valid trigger, move continues by signed offset past registration point.
// RL8 - Short, zero or opposite offset: decelerate then reverse to target.
// RL9 - With window enabled, only triggers inside window count.
// RL10 - Window bounds are unsigned distances from start, direction free.
// RL11 - No trigger before limit: stop at limit, set search limit flag.
// RL12 - Any move done sets on normal completion, clears on any start.
// RL13 - Accelerating flag while ramping up, cleared at speed or decel.
// RL14 - At speed flag set at target, kept through feed changes; code clears it on any accel or decel phase.
// RL15 - Move done set at decel end, held until restart, not on stop.
// RL16 - Move active from accel start to decel end.
// RL17 - Decelerating flag while slowing, cleared at zero or next target.
// RL18 - Timed index unreachable at start sets sticky time missed flag.
// RL19 - Time missed clears only on clear input edge.
// RL20 - Start on rising edge, refused during home, jog, program, stop, limit.
// RL21 - Configuration keeps switch on point below off point.
// RL22 - Registration index runs until trigger or limit, then offset.
// RL23 - All flags evaluated once per motion update.
module ims_core
	import ims_pkg::*;
#(
	parameter int NUM_IDX = IMS_NUM_IDX
) (
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        upd,
	input  wire logic [NUM_IDX-1:0]          start_in,
	input  wire logic                        home_busy,
	input  wire logic                        jog_busy,
	input  wire logic                        prog_busy,
	input  wire logic                        stop_in,
	input  wire logic                        travel_limit,
	input  wire logic                        drive_stop,
	input  wire logic [NUM_IDX-1:0]          idx_is_reg,
	input  wire logic [NUM_IDX-1:0]          idx_timed,
	input  wire logic                        time_unreachable,
	input  wire logic                        clear_time_target_missed,
	input  wire logic [IMS_POS_W-1:0]        sw_on_point,
	input  wire logic [IMS_POS_W-1:0]        sw_off_point,
	input  wire logic                        sw_enable,
	input  wire logic                        win_enable,
	input  wire logic [IMS_POS_W-1:0]        capture_window_open,
	input  wire logic [IMS_POS_W-1:0]        capture_window_close,
	input  wire logic signed [IMS_POS_W-1:0] reg_offset,
	input  wire logic [IMS_POS_W-1:0]        decel_dist,
	input  wire logic signed [IMS_POS_W-1:0] limit_dist,
	input  wire logic [1:0]                  src_sel,
	input  wire logic                        cmp_gt,
	input  wire logic signed [IMS_ANA_W-1:0] cmp_val,
	input  wire logic signed [IMS_ANA_W-1:0] analog_in,
	input  wire logic signed [IMS_ANA_W-1:0] torque_cmd,
	input  wire logic signed [IMS_ANA_W-1:0] torque_fb,
	input  wire logic                        capture_trigger_input,
	input  wire logic signed [IMS_POS_W-1:0] motor_pos,
	input  wire logic signed [IMS_POS_W-1:0] cmd_dist,
	input  wire logic [1:0]                  phase,
	input  wire logic                        ramp_done,
	output logic [IMS_IDX_W-1:0]             run_idx,
	output logic                             start_pulse,
	output logic                             target_valid,
	output logic signed [IMS_POS_W-1:0]      target_pos,
	output logic                             reverse_req,
	output logic                             limit_stop_req,
	output logic [NUM_IDX-1:0]               index_switch_output,
	output logic [NUM_IDX-1:0]               search_limit_reached,
	output logic [NUM_IDX-1:0]               accelerating,
	output logic [NUM_IDX-1:0]               at_target_speed,
	output logic [NUM_IDX-1:0]               decelerating,
	output logic [NUM_IDX-1:0]               move_active,
	output logic [NUM_IDX-1:0]               move_done,
	output logic                             any_move_done,
	output logic                             time_target_missed
);

	ims_state_t                   state_r, state_nxt;
	logic [NUM_IDX-1:0]           start_r, start_nxt;
	logic [IMS_IDX_W-1:0]         idx_r, idx_nxt;
	logic [NUM_IDX-1:0]           sw_r, sw_nxt;
	logic [NUM_IDX-1:0]           lim_r, lim_nxt;
	logic [NUM_IDX-1:0]           acc_r, acc_nxt;
	logic [NUM_IDX-1:0]           atv_r, atv_nxt;
	logic [NUM_IDX-1:0]           dec_r, dec_nxt;
	logic [NUM_IDX-1:0]           act_r, act_nxt;
	logic [NUM_IDX-1:0]           done_r, done_nxt;
	logic                         any_r, any_nxt;
	logic                         miss_r, miss_nxt;
	logic                         clr_r, clr_nxt;
	logic signed [IMS_POS_W-1:0]  spos_r, spos_nxt;
	logic signed [IMS_POS_W-1:0]  tgt_r, tgt_nxt;
	logic                         tv_r, tv_nxt;
	logic                         rev_r, rev_nxt;
	logic                         lreq_r, lreq_nxt;
	logic                         trig_evt;
	logic                         blocked;
	logic                         go;
	logic [IMS_IDX_W-1:0]         go_idx;
	logic [IMS_POS_W-1:0]         travel;
	logic                         win_ok;
	logic                         dir_neg;
	logic                         off_bad;

	ims_trig u_trig (
		.clk                   (clk),
		.rst_b                 (rst_b),
		.upd                   (upd),
		.src_sel               (src_sel),
		.cmp_gt                (cmp_gt),
		.cmp_val               (cmp_val),
		.analog_in             (analog_in),
		.torque_cmd            (torque_cmd),
		.torque_fb             (torque_fb),
		.capture_trigger_input (capture_trigger_input),
		.trig_evt              (trig_evt)
	);

	// ----------------------------------------------------------------
	// Start decode
	// ----------------------------------------------------------------
	assign blocked = home_busy || jog_busy || prog_busy || stop_in || travel_limit; // RL20

	always_comb begin
		go     = 1'b0;
		go_idx = '0;
		for (int i = NUM_IDX - 1; i >= 0; i--) begin
			if (start_in[i] && !start_r[i]) begin
				go     = !blocked && (state_r == IMS_IDLE); // RL20
				go_idx = IMS_IDX_W'(i);
			end
		end
	end

	assign travel  = ims_abs(cmd_dist); // RL10
	assign win_ok  = !win_enable
		|| ims_in_range(travel, capture_window_open, capture_window_close); // RL9
	assign dir_neg = limit_dist[IMS_POS_W-1];
	assign off_bad = (reg_offset == '0) || (reg_offset[IMS_POS_W-1] != dir_neg)
		|| (ims_abs(reg_offset) < decel_dist); // RL8

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		start_nxt = upd ? start_in : start_r;
		idx_nxt   = idx_r;
		sw_nxt    = sw_r;
		lim_nxt   = lim_r;
		acc_nxt   = acc_r;
		atv_nxt   = atv_r;
		dec_nxt   = dec_r;
		act_nxt   = act_r;
		done_nxt  = done_r;
		any_nxt   = any_r;
		miss_nxt  = miss_r;
		clr_nxt   = upd ? clear_time_target_missed : clr_r;
		spos_nxt  = spos_r;
		tgt_nxt   = tgt_r;
		tv_nxt    = tv_r;
		rev_nxt   = rev_r;
		lreq_nxt  = 1'b0;
		if (upd && clear_time_target_missed && !clr_r) begin
			miss_nxt = 1'b0; // RL19
		end
		if (upd) begin // RL23
			unique case (state_r)
				IMS_IDLE: begin
					if (go) begin
						state_nxt        = IMS_RUN;
						idx_nxt          = go_idx;
						sw_nxt[go_idx]   = 1'b0; // RL2
						done_nxt[go_idx] = 1'b0; // RL15
						lim_nxt[go_idx]  = 1'b0;
						act_nxt[go_idx]  = 1'b1; // RL16
						any_nxt          = 1'b0; // RL12
						tv_nxt           = 1'b0;
						rev_nxt          = 1'b0;
						spos_nxt         = motor_pos;
						if (idx_timed[go_idx] && time_unreachable) begin
							miss_nxt = 1'b1; // RL18
						end
					end
				end
				IMS_RUN, IMS_LIMIT: begin
					acc_nxt[idx_r] = (phase == IMS_PH_ACCEL); // RL13
					dec_nxt[idx_r] = (phase == IMS_PH_DECEL); // RL17
					if (phase == IMS_PH_CRUISE) begin
						atv_nxt[idx_r] = 1'b1; // RL14
					end else if (phase != IMS_PH_IDLE) begin
						atv_nxt[idx_r] = 1'b0; // RL14
					end
					if (sw_enable) begin
						sw_nxt[idx_r] = ims_in_range(travel, sw_on_point, sw_off_point); // RL1 RL4
					end
					if (state_r == IMS_RUN && idx_is_reg[idx_r] && !tv_r) begin
						if (trig_evt && win_ok) begin
							tv_nxt  = 1'b1; // RL6 RL22
							tgt_nxt = IMS_POS_W'(motor_pos + reg_offset); // RL7
							rev_nxt = off_bad; // RL8
						end else if (ims_abs(limit_dist) - travel <= decel_dist) begin
							state_nxt = IMS_LIMIT; // RL11
							lreq_nxt  = 1'b1;
						end
					end
					if (drive_stop || ramp_done) begin
						state_nxt      = IMS_FINISH;
						act_nxt[idx_r] = 1'b0; // RL16
						acc_nxt[idx_r] = 1'b0;
						dec_nxt[idx_r] = 1'b0;
						atv_nxt[idx_r] = 1'b0;
						if (!drive_stop) begin
							done_nxt[idx_r] = 1'b1; // RL15
							any_nxt         = 1'b1; // RL12
							lim_nxt[idx_r]  = (state_r == IMS_LIMIT); // RL11
						end
					end
				end
				IMS_FINISH: begin
					// Switch state freezes here until the same index restarts.
					state_nxt = IMS_IDLE; // RL2 RL3
					tv_nxt    = 1'b0;
				end
				default: state_nxt = IMS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r <= IMS_IDLE;
			start_r <= '0;
			idx_r   <= '0;
			sw_r    <= '0;
			lim_r   <= '0;
			acc_r   <= '0;
			atv_r   <= '0;
			dec_r   <= '0;
			act_r   <= '0;
			done_r  <= '0;
			any_r   <= 1'b0;
			miss_r  <= 1'b0;
			clr_r   <= 1'b0;
			spos_r  <= '0;
			tgt_r   <= '0;
			tv_r    <= 1'b0;
			rev_r   <= 1'b0;
			lreq_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			start_r <= start_nxt;
			idx_r   <= idx_nxt;
			sw_r    <= sw_nxt;
			lim_r   <= lim_nxt;
			acc_r   <= acc_nxt;
			atv_r   <= atv_nxt;
			dec_r   <= dec_nxt;
			act_r   <= act_nxt;
			done_r  <= done_nxt;
			any_r   <= any_nxt;
			miss_r  <= miss_nxt;
			clr_r   <= clr_nxt;
			spos_r  <= spos_nxt;
			tgt_r   <= tgt_nxt;
			tv_r    <= tv_nxt;
			rev_r   <= rev_nxt;
			lreq_r  <= lreq_nxt;
		end
	end

	assign run_idx              = idx_r;
	assign start_pulse          = upd && go;
	assign target_valid         = tv_r;
	assign target_pos           = tgt_r;
	assign reverse_req          = rev_r;
	assign limit_stop_req       = lreq_r;
	assign index_switch_output  = sw_r;
	assign search_limit_reached = lim_r;
	assign accelerating         = acc_r;
	assign at_target_speed      = atv_r;
	assign decelerating         = dec_r;
	assign move_active          = act_r;
	assign move_done            = done_r;
	assign any_move_done        = any_r;
	assign time_target_missed   = miss_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_clr_edge;
		upd && clear_time_target_missed && !clr_r;
	endsequence

	a_start_blocked: assert property (@(posedge clk) disable iff (!rst_b)
		(upd && blocked) |=> !(|(act_r & ~$past(act_r)))) else $error("start while blocked"); // RL20
	a_done_clears_any: assert property (@(posedge clk) disable iff (!rst_b)
		start_pulse |=> !any_r) else $error("any done not cleared"); // RL12
	a_stop_no_done: assert property (@(posedge clk) disable iff (!rst_b)
		(upd && drive_stop && state_r == IMS_RUN) |=> !done_r[$past(idx_r)])
		else $error("done after stop"); // RL15
	a_miss_clear_edge: assert property (@(posedge clk) disable iff (!rst_b)
		(miss_r && !miss_nxt) |-> s_clr_edge) else $error("miss cleared without edge"); // RL19
	a_miss_sticky: assert property (@(posedge clk) disable iff (!rst_b)
		(start_pulse && idx_timed[go_idx] && time_unreachable) |=> miss_r)
		else $error("miss not set"); // RL18
	a_acc_dec_excl: assert property (@(posedge clk) disable iff (!rst_b)
		!(|(acc_r & dec_r))) else $error("accel and decel together"); // RL13
	a_atv_not_ramp: assert property (@(posedge clk) disable iff (!rst_b)
		!(|(atv_r & (acc_r | dec_r)))) else $error("at speed during ramp"); // RL14
	a_switch_window: assert property (@(posedge clk) disable iff (!rst_b)
		(upd && sw_enable && state_r == IMS_RUN && !drive_stop && !ramp_done)
		|=> sw_r[$past(idx_r)] == $past(ims_in_range(travel, sw_on_point, sw_off_point)))
		else $error("switch output wrong"); // RL1
	a_switch_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == IMS_IDLE && !start_pulse) |=> $stable(sw_r)) else $error("switch moved"); // RL2
	a_active_done: assert property (@(posedge clk) disable iff (!rst_b)
		!(|(act_r & done_r))) else $error("active and done together"); // RL16

endmodule : ims_core

// *** rtl/ims_trig.sv ***
// Registration trigger selection and comparison.
// Assumes all inputs are synchronous to clk and sampled once per update.
module ims_trig
	import ims_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        upd,
	input  wire logic [1:0]                  src_sel,
	input  wire logic                        cmp_gt,
	input  wire logic signed [IMS_ANA_W-1:0] cmp_val,
	input  wire logic signed [IMS_ANA_W-1:0] analog_in,
	input  wire logic signed [IMS_ANA_W-1:0] torque_cmd,
	input  wire logic signed [IMS_ANA_W-1:0] torque_fb,
	input  wire logic                        capture_trigger_input,
	output logic                             trig_evt
);

	logic                        lvl;
	logic                        lvl_r;
	logic                        lvl_nxt;
	logic signed [IMS_ANA_W-1:0] sample;

	// ----------------------------------------------------------------
	// Trigger level
	// ----------------------------------------------------------------
	always_comb begin
		unique case (src_sel)
			IMS_SRC_TQ_CMD: sample = torque_cmd;
			IMS_SRC_TQ_FB:  sample = torque_fb;
			default:        sample = analog_in;
		endcase
		if (src_sel == IMS_SRC_SENSOR) begin
			lvl = capture_trigger_input; // RL5
		end else begin
			lvl = cmp_gt ? (sample > cmp_val) : (sample < cmp_val); // RL5
		end
		lvl_nxt = upd ? lvl : lvl_r;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lvl_r <= 1'b0;
		end else begin
			lvl_r <= lvl_nxt;
		end
	end

	// Fires on the update in which the condition becomes true.
	assign trig_evt = upd && lvl && !lvl_r; // RL5

	a_trig_edge: assert property (@(posedge clk) disable iff (!rst_b)
		trig_evt |=> lvl_r) else $error("trigger level not held"); // RL5

endmodule : ims_trig

// *** verif/ims_prof_model.sv ***
// Profile generator model standing in for the drive position loop.
// Assumes the core's start pulse and stop requests are synchronous to clk.
module ims_prof_model
	import ims_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        start_pulse,
	input  wire logic                        stop_req,
	input  wire logic                        drive_stop,
	input  wire logic signed [IMS_POS_W-1:0] move_len,
	output logic                             upd,
	output logic [1:0]                       phase,
	output logic signed [IMS_POS_W-1:0]      cmd_dist,
	output logic signed [IMS_POS_W-1:0]      motor_pos,
	output logic                             ramp_done
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int        STEP = 10;
	localparam int        RAMP = 30;
	logic [1:0]           div_r;
	logic                 run_r;
	logic                 neg_r;
	logic [IMS_POS_W-1:0] end_r;
	logic [IMS_POS_W-1:0] mag;
	logic [IMS_POS_W-1:0] nxt;

	assign mag       = neg_r ? IMS_POS_W'(-cmd_dist) : IMS_POS_W'(cmd_dist);
	assign nxt       = mag + IMS_POS_W'(STEP);
	assign motor_pos = cmd_dist + 32'sh0000_1000;

	// A stop request only ever shortens the remaining travel to one ramp.
	always @(posedge clk) begin
		div_r <= div_r + 2'h1;
		upd   <= (div_r == 2'h3);
		if (run_r && stop_req && end_r > mag + IMS_POS_W'(RAMP))
			end_r <= mag + IMS_POS_W'(RAMP);
		if (upd) begin
			ramp_done <= 1'b0;
			if (start_pulse) begin
				run_r    <= 1'b1;
				neg_r    <= move_len[IMS_POS_W-1];
				end_r    <= move_len[IMS_POS_W-1] ? IMS_POS_W'(-move_len) : IMS_POS_W'(move_len);
				cmd_dist <= '0;
				phase    <= IMS_PH_ACCEL;
			end else if (run_r && drive_stop) begin
				run_r <= 1'b0;
				phase <= IMS_PH_IDLE;
			end else if (run_r && nxt >= end_r) begin
				run_r     <= 1'b0;
				ramp_done <= 1'b1;
				phase     <= IMS_PH_IDLE;
				cmd_dist  <= neg_r ? -$signed(end_r) : $signed(end_r);
			end else if (run_r) begin
				cmd_dist <= neg_r ? cmd_dist - STEP : cmd_dist + STEP;
				phase    <= (nxt < IMS_POS_W'(RAMP)) ? IMS_PH_ACCEL :
					(nxt + IMS_POS_W'(RAMP) >= end_r) ? IMS_PH_DECEL : IMS_PH_CRUISE;
			end
		end
		if (!rst_b) begin
			div_r     <= 2'h0;
			upd       <= 1'b0;
			run_r     <= 1'b0;
			ramp_done <= 1'b0;
			phase     <= IMS_PH_IDLE;
			cmd_dist  <= '0;
		end
	end
endmodule : ims_prof_model

// *** verif/testbench.sv ***
// Self-checking bench for the index status core driven by a profile model.
// Assumes a 20 MHz clock and the constants of ims_pkg.
module testbench
	import ims_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                        clk = 1'b0, rst_b = 1'b0;
	logic [7:0]                  start_in = '0, idx_is_reg = '0, idx_timed = '0;
	logic [4:0]                  blk = '0;
	logic                        drive_stop = 1'b0, unreach = 1'b0, clr = 1'b0, win_en = 1'b0;
	logic                        trig = 1'b0, cmp_gt = 1'b1, upd, ramp_done, start_pulse;
	logic                        tgt_valid, reverse_req, lim_stop, any_done, ttm;
	logic [1:0]                  src_sel = 2'h3, phase;
	logic [IMS_POS_W-1:0]        win_open = '0, win_close = '0;
	logic signed [IMS_POS_W-1:0] offset = '0, move_len = '0, lim_dist = '0;
	logic signed [IMS_POS_W-1:0] pos, cmd_dist, motor_pos, tgt_pos;
	logic signed [IMS_ANA_W-1:0] cmp_val = 16'sh0032, ana [3] = '{default: '0};
	logic [7:0]                  sw, lim_hit, acc, at_spd, dec, active, done;
	logic [IMS_IDX_W-1:0]        ridx;
	logic                        lim_seen = 1'b0;
	int                          err_total = 0, samples_checked = 0, cyc = 0;

	ims_core #(.NUM_IDX(8)) i_dut (.clk(clk), .rst_b(rst_b), .upd(upd), .start_in(start_in),
		.home_busy(blk[0]), .jog_busy(blk[1]), .prog_busy(blk[2]), .stop_in(blk[3]),
		.travel_limit(blk[4]), .drive_stop(drive_stop), .idx_is_reg(idx_is_reg),
		.idx_timed(idx_timed), .time_unreachable(unreach), .clear_time_target_missed(clr),
		.sw_on_point(32'h0000_0028), .sw_off_point(32'h0000_0064), .sw_enable(1'b1),
		.win_enable(win_en), .capture_window_open(win_open),
		.capture_window_close(win_close), .reg_offset(offset), .decel_dist(32'h0000_001E),
		.limit_dist(lim_dist), .src_sel(src_sel), .cmp_gt(cmp_gt), .cmp_val(cmp_val),
		.analog_in(ana[0]), .torque_cmd(ana[1]), .torque_fb(ana[2]),
		.capture_trigger_input(trig), .motor_pos(motor_pos), .cmd_dist(cmd_dist),
		.phase(phase), .ramp_done(ramp_done), .run_idx(ridx), .start_pulse(start_pulse),
		.target_valid(tgt_valid), .target_pos(tgt_pos), .reverse_req(reverse_req),
		.limit_stop_req(lim_stop), .index_switch_output(sw), .search_limit_reached(lim_hit),
		.accelerating(acc), .at_target_speed(at_spd), .decelerating(dec),
		.move_active(active), .move_done(done), .any_move_done(any_done),
		.time_target_missed(ttm));

	ims_prof_model i_prof (.clk(clk), .rst_b(rst_b), .start_pulse(start_pulse),
		.stop_req(tgt_valid | lim_stop), .drive_stop(drive_stop), .move_len(move_len),
		.upd(upd), .phase(phase), .cmd_dist(cmd_dist), .motor_pos(motor_pos),
		.ramp_done(ramp_done));

	initial forever #25 clk = ~clk;

	// The limit stop request is a one-cycle pulse, so it is caught in a sticky flag.
	always @(posedge clk) begin
		if (lim_stop)
			lim_seen <= 1'b1;
	end

	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			err_total = err_total + 1;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// Access and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [IMS_POS_W-1:0] got, input logic [IMS_POS_W-1:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Advances to one cycle after the next update, when the flags are settled.
	task automatic step();
		@(posedge clk iff upd);
		@(posedge clk);
		#1;
	endtask : step

	task automatic wait_dist(input int d);
		for (int n = 0; n < 100 && (cmd_dist < 0 ? -cmd_dist : cmd_dist) < d; n++)
			step();
	endtask : wait_dist

	task automatic wait_done();
		for (int n = 0; n < 200 && active !== 8'h0; n++)
			step();
		step();
	endtask : wait_done

	task automatic go(input int i, input int len);
		@(posedge clk);
		move_len    <= len;
		lim_dist    <= len;
		start_in[i] <= 1'b1;
		@(posedge clk iff upd);
		@(posedge clk);
		start_in[i] <= 1'b0;
		#1;
	endtask : go

	// Flag order in e: switch, accelerating, at speed, decelerating.
	task automatic at_dist(input int d, input int i, input logic [3:0] e);
		wait_dist(d);
		step();
		chk(active[i], 1'b1);
		chk({sw[i], acc[i], at_spd[i], dec[i]}, e);
	endtask : at_dist

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		step();
		chk({active, done, sw, any_done, ttm}, '0);
		$display("test reset done");
		go(0, 200);
		at_dist(10, 0, 4'h4);
		at_dist(70, 0, 4'hA);
		at_dist(150, 0, 4'h2);
		at_dist(180, 0, 4'h1);
		wait_done();
		chk({done[0], any_done, active[0], acc[0], dec[0]}, 5'h18);
		go(1, -200);
		chk({any_done, done[0]}, 2'h1);
		at_dist(70, 1, 4'hA);
		wait_done();
		$display("test switch done");
		go(2, 60);
		wait_done();
		chk(sw[2], 1'b1);
		go(3, 30);
		wait_done();
		chk(sw[3], 1'b0);
		go(2, 200);
		at_dist(10, 2, 4'h4);
		wait_done();
		$display("test short done");
		for (int b = 0; b < 5; b++) begin
			@(posedge clk) blk <= 5'h01 << b;
			go(7, 200);
			step();
			chk(active[7], 1'b0);
			@(posedge clk) blk <= 5'h00;
		end
		go(7, 200);
		chk(active[7], 1'b1);
		chk(ridx, 3'h7);
		wait_dist(50);
		@(posedge clk) drive_stop <= 1'b1;
		wait_done();
		chk({done[7], any_done}, 2'h0);
		@(posedge clk) drive_stop <= 1'b0;
		$display("test start done");
		idx_timed[5] <= 1'b1;
		unreach <= 1'b1;
		go(5, 30);
		chk(ttm, 1'b1);
		wait_done();
		@(posedge clk) clr <= 1'b1;
		step();
		step();
		chk(ttm, 1'b0);
		go(5, 30);
		chk(ttm, 1'b1);
		wait_done();
		@(posedge clk) clr <= 1'b0;
		step();
		chk(ttm, 1'b1);
		@(posedge clk) clr <= 1'b1;
		step();
		step();
		chk(ttm, 1'b0);
		$display("test timed done");
		@(posedge clk);
		idx_is_reg[6] <= 1'b1;
		win_en <= 1'b1;
		win_open <= 32'h0000_0032;
		win_close <= 32'h0000_0078;
		offset <= 32'sh0000_0064;
		go(6, 400);
		wait_dist(20);
		@(posedge clk) trig <= 1'b1;
		step();
		chk(tgt_valid, 1'b0);
		@(posedge clk) trig <= 1'b0;
		wait_dist(80);
		@(posedge clk) trig <= 1'b1;
		pos = motor_pos;
		step();
		chk({tgt_valid, reverse_req}, 2'h2);
		chk(tgt_pos, pos + 32'sh0000_0064);
		wait_done();
		@(posedge clk) trig <= 1'b0;
		go(6, 200);
		wait_done();
		chk(lim_hit[6], 1'b1);
		chk(lim_seen, 1'b1);
		$display("test sensor done");
		@(posedge clk);
		win_en <= 1'b0;
		offset <= '0;
		for (int s = 0; s < 3; s++) begin
			@(posedge clk) src_sel <= 2'(s);
			cmp_gt <= (s != 1);
			ana[s] <= (s == 1) ? 16'sh0064 : 16'sh0000;
			go(6, 400);
			wait_dist(60);
			@(posedge clk) ana[s] <= (s == 1) ? 16'sh0000 : 16'sh0064;
			step();
			chk({tgt_valid, reverse_req}, 2'h3);
			wait_done();
			@(posedge clk) ana[s] <= 16'sh0000;
		end
		$display("test analog done");
		summarize();
	end
endmodule : testbench
